/* File: hw/tpg_gpio.sv */
`timescale 1ns/10ps
`default_nettype none
module tpg_gpio (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [tpg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tpg_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tpg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tpg_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p1_pullup_en,
    output logic [7:0] p1_analog_en,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    output logic [7:0] p2_pullup_en,
    input wire logic [3:0] p3_in,
    output logic [3:0] p3_out,
    output logic [3:0] p3_oe,
    output logic [3:0] p3_pullup_en,
    input wire logic buzzer_in,
    input wire logic pdm_in,
    output logic pdm_output_enable,
    output logic prog_counter_enable,
    output logic [3:0] ext_irq_event
);
    import tpg_pkg::*;

    // ****************************************
    // Register bus.
    // ****************************************
    logic [7:0] port1_data, port1_direction;
    logic [7:0] port1_pullup, port1_analog_select;
    logic [7:0] port2_data, port2_direction;
    logic [7:0] port2_pullup, port2_mode;
    logic [7:0] port3_data, port3_direction;
    logic [7:0] port3_pullup, port3_mode;
    logic [7:0] port2_open_drain;
    logic aw_held, w_held;
    logic [5:0] wr_idx;
    logic [7:0] wd;
    logic wr_lane;
    logic do_wr, wr_en;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic ar_fire;
    logic [7:0] p1_s1, p1_s2, p2_s1, p2_s2;
    logic [3:0] p3_s1, p3_s2;
    logic [3:0] irq_prev;
    logic [2:0] sync_fill;
    logic [7:0] next_p2_out, next_p2_oe;

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx >= IDX_P1_DATA && idx <= IDX_P3_MODE) || idx == IDX_P2_OD;
    endfunction

    function automatic logic trig(input logic [1:0] m, input logic prev, input logic cur);
        unique case (m)
            TRIG_FALL: trig = prev & ~cur;
            TRIG_RISE: trig = ~prev & cur;
            TRIG_ANY: trig = prev ^ cur;
            TRIG_ANY_ALT: trig = prev ^ cur;
        endcase
    endfunction

    // Address and data are taken in either order; a write waits for both.
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_wr = aw_held & w_held & ~s_axi_bvalid;
    assign wr_en = do_wr & wr_lane;
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_fire = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_idx <= 6'h00;
            wd <= REG_RESET;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_idx <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wd <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Input pins of port 1 read through the select gate; output pins read the latch.
    always_comb begin
        rd_byte = REG_RESET;
        rd_ok = 1'b1;
        case (s_axi_araddr[7:2])
            IDX_P1_DATA: rd_byte = (port1_direction & port1_data)
                | (~port1_direction & p1_s2 & port1_analog_select); // RQ14 RQ21
            IDX_P1_DIR: rd_byte = port1_direction;
            IDX_P1_PU: rd_byte = port1_pullup;
            IDX_P1_SEL: rd_byte = port1_analog_select;
            IDX_P2_DATA: rd_byte = (port2_direction & port2_data) | (~port2_direction & p2_s2);
            IDX_P2_DIR: rd_byte = port2_direction;
            IDX_P2_PU: rd_byte = port2_pullup;
            IDX_P2_MODE: rd_byte = port2_mode;
            IDX_P3_DATA: rd_byte = P3_MASK & ((port3_direction & port3_data)
                | (~port3_direction & {4'h0, p3_s2})); // RQ6
            IDX_P3_DIR: rd_byte = port3_direction;
            IDX_P3_PU: rd_byte = port3_pullup;
            IDX_P3_MODE: rd_byte = port3_mode;
            IDX_P2_OD: rd_byte = port2_open_drain;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= {RD_PAD, REG_RESET};
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {RD_PAD, rd_byte};
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Control registers.
    // ****************************************
    // The data latches are cleared too, so no unknown ever reaches a pin.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            port1_data <= REG_RESET;
            port1_direction <= REG_RESET; // RQ19
            port1_pullup <= REG_RESET; // RQ19
            port1_analog_select <= REG_RESET; // RQ19
            port2_data <= REG_RESET;
            port2_direction <= REG_RESET;
            port2_pullup <= REG_RESET;
            port2_mode <= REG_RESET;
            port3_data <= REG_RESET;
            port3_direction <= REG_RESET;
            port3_pullup <= REG_RESET;
            port3_mode <= REG_RESET;
            port2_open_drain <= OD_RESET; // RQ12
        end else if (wr_en) begin
            case (wr_idx)
                IDX_P1_DATA: port1_data <= wd; // RQ15
                IDX_P1_DIR: port1_direction <= wd; // RQ13
                IDX_P1_PU: port1_pullup <= wd;
                IDX_P1_SEL: port1_analog_select <= wd;
                IDX_P2_DATA: port2_data <= wd; // RQ15
                IDX_P2_DIR: port2_direction <= wd;
                IDX_P2_PU: port2_pullup <= wd;
                IDX_P2_MODE: port2_mode <= wd & MODE2_MASK; // RQ22
                IDX_P3_DATA: port3_data <= wd & P3_MASK; // RQ6 RQ15
                IDX_P3_DIR: port3_direction <= wd & P3_MASK; // RQ22
                IDX_P3_PU: port3_pullup <= wd & P3_MASK; // RQ22
                IDX_P3_MODE: port3_mode <= wd & MODE3_MASK; // RQ22
                IDX_P2_OD: port2_open_drain <= wd & OD_MASK; // RQ22
                default: ;
            endcase
        end
    end

    // ****************************************
    // Pins.
    // ****************************************
    assign p1_out = port1_data; // RQ15
    assign p1_oe = port1_direction; // RQ13
    assign p1_pullup_en = port1_pullup; // RQ16
    assign p1_analog_en = ~port1_analog_select; // RQ21
    assign p2_pullup_en = port2_pullup; // RQ1
    assign p3_out = port3_data[3:0];
    assign p3_oe = port3_direction[3:0]; // RQ7
    assign p3_pullup_en = port3_pullup[3:0]; // RQ8
    assign pdm_output_enable = port2_mode[PDM_BIT]; // RQ3
    assign prog_counter_enable = port3_mode[PC_BIT]; // RQ9

    // An open-drain pin only ever pulls low; a one leaves it to the pull-up.
    always_comb begin
        next_p2_out = port2_data;
        next_p2_oe = port2_direction; // RQ20
        for (int i = OD_LO_PIN; i <= OD_HI_PIN; i++) begin
            if (port2_open_drain[i]) begin
                next_p2_out[i] = 1'b0; // RQ12
                next_p2_oe[i] = port2_direction[i] & ~port2_data[i]; // RQ12
            end
        end
        if (port2_mode[PDM_BIT]) begin
            next_p2_out[PDM_PIN] = pdm_in; // RQ3
            next_p2_oe[PDM_PIN] = 1'b1; // RQ3
        end
        if (port2_mode[BZ_BIT]) begin
            next_p2_out[BZ_PIN] = buzzer_in; // RQ2
            next_p2_oe[BZ_PIN] = 1'b1; // RQ2
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            p2_out <= REG_RESET;
            p2_oe <= REG_RESET;
        end else begin
            p2_out <= next_p2_out;
            p2_oe <= next_p2_oe;
        end
    end

    // ****************************************
    // Input sampling and interrupt triggers.
    // ****************************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            p1_s1 <= REG_RESET;
            p1_s2 <= REG_RESET;
            p2_s1 <= REG_RESET;
            p2_s2 <= REG_RESET;
            p3_s1 <= 4'h0;
            p3_s2 <= 4'h0;
        end else begin
            p1_s1 <= p1_in;
            p1_s2 <= p1_s1;
            p2_s1 <= p2_in;
            p2_s2 <= p2_s1;
            p3_s1 <= p3_in;
            p3_s2 <= p3_s1;
        end
    end

    // The sync stages wake up at zero, so a pin idling high would fake an edge.
    // Detection therefore waits until the stages and the previous-value flops hold real pin levels.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_fill <= 3'h0;
        end else begin
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    // Edges are seen on the second sync stage, so an event lags the pin by three cycles.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_prev <= 4'h0;
            ext_irq_event <= 4'h0;
        end else begin
            irq_prev <= {p3_s2[1:0], p2_s2[1:0]};
            ext_irq_event[0] <= sync_fill[2] & trig(port2_mode[TRIG_LO_LSB+:2], irq_prev[0], p2_s2[0]); // RQ5
            ext_irq_event[1] <= sync_fill[2] & trig(port2_mode[TRIG_HI_LSB+:2], irq_prev[1], p2_s2[1]); // RQ4
            ext_irq_event[2] <= sync_fill[2] & trig(port3_mode[TRIG_LO_LSB+:2], irq_prev[2], p3_s2[0]); // RQ11
            ext_irq_event[3] <= sync_fill[2] & trig(port3_mode[TRIG_HI_LSB+:2], irq_prev[3], p3_s2[1]); // RQ10
        end
    end

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    pullup_two_a: assert property (wr_en && wr_idx == IDX_P2_PU |=> p2_pullup_en == $past(wd)) // RQ1
        else $error("port 2 pull-up not taken");
    buzzer_pin_a: assert property (port2_mode[BZ_BIT] |=> p2_oe[BZ_PIN] && p2_out[BZ_PIN] == $past(buzzer_in)) // RQ2
        else $error("buzzer not on pin 7");
    pdm_pin_a: assert property (port2_mode[PDM_BIT] |=> p2_oe[PDM_PIN] && p2_out[PDM_PIN] == $past(pdm_in)) // RQ3
        else $error("pdm not on pin 2");
    irq0_fall_a: assert property (port2_mode[1:0] == TRIG_FALL && irq_prev[0] && !p2_s2[0] |=> ext_irq_event[0]) // RQ5
        else $error("falling edge missed");
    irq1_rise_a: assert property (port2_mode[3:2] == TRIG_RISE && $rose(p2_s2[1]) |=> ext_irq_event[1]) // RQ4
        else $error("rising edge missed");
    irq2_quiet_a: assert property ($stable(p3_s2[0]) && $stable(irq_prev[2]) && irq_prev[2] == p3_s2[0] // RQ11
        |=> !ext_irq_event[2])
        else $error("event without edge");
    port3_upper_a: assert property (ar_fire && s_axi_araddr[7:2] == IDX_P3_DATA |=> s_axi_rdata[7:4] == 4'h0) // RQ6
        else $error("port 3 upper bits not zero");
    dir_three_a: assert property (wr_en && wr_idx == IDX_P3_DIR |=> {4'h0, p3_oe} == ($past(wd) & P3_MASK)) // RQ7
        else $error("port 3 direction not taken");
    pullup_three_a: assert property (wr_en && wr_idx == IDX_P3_PU |=> {4'h0, p3_pullup_en} == ($past(wd) & P3_MASK)) // RQ8
        else $error("port 3 pull-up not taken");
    dir_one_a: assert property (wr_en && wr_idx == IDX_P1_DIR |=> p1_oe == $past(wd)) // RQ13
        else $error("port 1 direction not taken");
    dir_two_a: assert property (!port2_mode[BZ_BIT] && !port2_mode[PDM_BIT] && port2_open_drain == REG_RESET // RQ20
        |=> p2_oe == $past(port2_direction))
        else $error("port 2 direction not followed");
    open_drain_a: assert property (port2_open_drain[3] |=> !p2_out[3]) // RQ12
        else $error("open-drain pin drove high");
    p1_gate_a: assert property (ar_fire && s_axi_araddr[7:2] == IDX_P1_DATA |=> // RQ14
        (s_axi_rdata[7:0] & ~$past(port1_direction))
        == ($past(p1_s2) & $past(port1_analog_select) & ~$past(port1_direction)))
        else $error("port 1 gate wrong");
    latch_hold_a: assert property (!(wr_en && wr_idx == IDX_P1_DATA) |=> $stable(p1_out)) // RQ15
        else $error("port 1 latch moved");

    write_done_c: cover property (do_wr ##1 s_axi_bvalid && s_axi_bready);
    read_done_c: cover property (ar_fire ##1 s_axi_rvalid && s_axi_rready);
    irq_any_c: cover property (port3_mode[3:2] == TRIG_ANY && ext_irq_event[3]);
    buzzer_on_c: cover property (port2_mode[BZ_BIT] && p2_oe[BZ_PIN]);
    open_drain_c: cover property (port2_open_drain[OD_HI_PIN] && p2_oe[OD_HI_PIN]);
endmodule
`default_nettype wire

/* File: hw/tpg_pkg.sv */
// How it works
// RQ1: Port 2 pull-up bit high connects that pin's pull-up, low removes it.
// RQ2: Port 2 mode bit 7 high gives pin 7 to the buzzer, else GPIO.
// RQ3: Port 2 mode bit 4 high gives pin 2 to the PDM output, else GPIO.
// RQ4: Port 2 mode bits 3-2 pick interrupt 1 trigger: fall, rise, any change.
// RQ5: Port 2 mode bits 1-0 pick interrupt 0 trigger: fall, rise, any change.
// RQ6: Port 3 data keeps only bits 3-0; upper bits are absent.
// RQ7: Port 3 direction bit low makes an input, high an output.
// RQ8: Port 3 pull-up bit high connects the pull-up, low removes it.
// RQ9: Port 3 mode bit 4 enables the programmable counter.
// RQ10: Port 3 mode bits 3-2 pick pin 1 interrupt trigger.
// RQ11: Port 3 mode bits 1-0 pick pin 0 interrupt trigger.
// RQ12: Open-drain bits 4 and 3 make port 2 pins open drain; reset high.
// RQ13: Port 1 direction sets each of its eight pins separately.
// RQ14: Port 1 select high passes the digital input to reads, else analog only.
// RQ15: A data register write latches the byte into the output flops until rewritten.
// RQ16: A pulled-up port 1 input with nothing driving it reads one.
// RQ17: Software clears direction, may set pull-up, then reads port 1 data.
// RQ18: Software enables the analog regulator before using the analog inputs.
// RQ19: Port 1 direction, pull-up and select read zero after reset.
// RQ20: Port 2 direction bit low makes an input, high an output.
// RQ21: Port 1 select bit low means analog channel, high digital channel.
// RQ22: Absent register bits ignore writes and read zero.
`default_nettype none
package tpg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [5:0] IDX_P1_DATA = 6'h20;
    localparam logic [5:0] IDX_P1_DIR = 6'h21;
    localparam logic [5:0] IDX_P1_PU = 6'h22;
    localparam logic [5:0] IDX_P1_SEL = 6'h23;
    localparam logic [5:0] IDX_P2_DATA = 6'h24;
    localparam logic [5:0] IDX_P2_DIR = 6'h25;
    localparam logic [5:0] IDX_P2_PU = 6'h26;
    localparam logic [5:0] IDX_P2_MODE = 6'h27;
    localparam logic [5:0] IDX_P3_DATA = 6'h28;
    localparam logic [5:0] IDX_P3_DIR = 6'h29;
    localparam logic [5:0] IDX_P3_PU = 6'h2a;
    localparam logic [5:0] IDX_P3_MODE = 6'h2b;
    localparam logic [5:0] IDX_P2_OD = 6'h37;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] OD_RESET = 8'h18;
    localparam logic [7:0] OD_MASK = 8'h18;
    localparam logic [7:0] P3_MASK = 8'h0f;
    localparam logic [7:0] MODE2_MASK = 8'h9f;
    localparam logic [7:0] MODE3_MASK = 8'h1f;
    localparam logic [23:0] RD_PAD = 24'h000000;
    localparam int BZ_BIT = 7;
    localparam int PDM_BIT = 4;
    localparam int PC_BIT = 4;
    localparam int TRIG_HI_LSB = 2;
    localparam int TRIG_LO_LSB = 0;
    localparam int BZ_PIN = 7;
    localparam int PDM_PIN = 2;
    localparam int OD_LO_PIN = 3;
    localparam int OD_HI_PIN = 4;
    typedef enum logic [1:0] {
        TRIG_FALL = 2'b00,
        TRIG_RISE = 2'b01,
        TRIG_ANY = 2'b10,
        TRIG_ANY_ALT = 2'b11
    } tpg_trig_t;
endpackage
`default_nettype wire

/* File: verif/tpg_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Off-chip circuit on one port.
// ****************************************
module tpg_pin_model #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pullup_en,
    input wire logic [W-1:0] drv_en,
    input wire logic [W-1:0] drv_val,
    output logic [W-1:0] pin
);
    logic flt = 1'b0;
    // A pin nobody drives or pulls up toggles every cycle, so a stale level can never pass for a real one.
    always @(posedge ref_clk) begin
        flt <= ~flt;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) begin
                pin[i] = pin_out[i];
            end else if (drv_en[i]) begin
                pin[i] = drv_val[i];
            end else if (pullup_en[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = flt;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/three_port_gpio_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module three_port_gpio_control_tb;
    import tpg_pkg::*;
    logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, buzzer_in, pdm_in, pdm_output_enable;
    logic prog_counter_enable;
    logic [7:0] s_axi_awaddr, s_axi_araddr, p1_in, p1_out, p1_oe, p1_pullup_en, p1_analog_en;
    logic [7:0] p2_in, p2_out, p2_oe, p2_pullup_en, d1_en, d1_v, d2_en, d2_v;
    logic [3:0] s_axi_wstrb, p3_in, p3_out, p3_oe, p3_pullup_en, ext_irq_event, d3_en, d3_v;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] ev_cnt [4];
    int bad_count, check_count, cyc;
    tpg_gpio i_dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p1_in, .p1_out, .p1_oe,
        .p1_pullup_en, .p1_analog_en, .p2_in, .p2_out, .p2_oe, .p2_pullup_en, .p3_in, .p3_out, .p3_oe,
        .p3_pullup_en, .buzzer_in, .pdm_in, .pdm_output_enable, .prog_counter_enable, .ext_irq_event);
    tpg_pin_model #(.W(8)) i_p1 (.ref_clk, .pin_out(p1_out), .pin_oe(p1_oe), .pullup_en(p1_pullup_en),
        .drv_en(d1_en), .drv_val(d1_v), .pin(p1_in));
    tpg_pin_model #(.W(8)) i_p2 (.ref_clk, .pin_out(p2_out), .pin_oe(p2_oe), .pullup_en(p2_pullup_en),
        .drv_en(d2_en), .drv_val(d2_v), .pin(p2_in));
    tpg_pin_model #(.W(4)) i_p3 (.ref_clk, .pin_out(p3_out), .pin_oe(p3_oe), .pullup_en(p3_pullup_en),
        .drv_en(d3_en), .drv_val(d3_v), .pin(p3_in));
    // ****************************************
    // Clock, timeout and event counting.
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        for (int i = 0; i < 4; i++) begin
            if (ext_irq_event[i] === 1'b1) ev_cnt[i] <= ev_cnt[i] + 8'h01;
        end
        if (cyc == 10000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ****************************************
    // Helpers.
    // ****************************************
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Handshakes are judged at the falling edge, where nothing moves, and acted on at the next rising edge.
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic a_hs, w_hs, done;
        logic [1:0] r;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge ref_clk);
            a_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (a_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
        logic hs, done;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge ref_clk);
            hs = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (hs) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h000000, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset();
        rd(8'h84, 8'h00);
        rd(8'h88, 8'h00);
        rd(8'h8c, 8'h00);
        rd(8'hdc, 8'h18);
        chk("p1_analog_en", 32'hff, {24'h0, p1_analog_en});
    endtask
    task automatic t_regs();
        logic [7:0] ad [10] = '{8'h84, 8'h88, 8'h98, 8'h9c, 8'ha4, 8'ha8, 8'hac, 8'ha0, 8'hdc, 8'hfc};
        logic [7:0] ex [10] = '{8'hff, 8'hff, 8'h5a, 8'h9f, 8'h0f, 8'h0f, 8'h1f, 8'h0f, 8'h18, 8'h00};
        for (int i = 0; i < 10; i++) begin
            wr(ad[i], (i == 2) ? 8'h5a : 8'hff, (i == 9) ? RESP_SLVERR : RESP_OKAY);
            rd(ad[i], ex[i], (i == 9) ? RESP_SLVERR : RESP_OKAY);
        end
        settle(2);
        chk("p1_oe", 32'hff, {24'h0, p1_oe});
        chk("p2_pullup_en", 32'h5a, {24'h0, p2_pullup_en});
        chk("p3_oe", 32'hf, {28'h0, p3_oe});
        chk("p3_pullup_en", 32'hf, {28'h0, p3_pullup_en});
        chk("p3_out", 32'hf, {28'h0, p3_out});
        chk("prog_counter_enable", 32'h1, {31'h0, prog_counter_enable});
        chk("pdm_output_enable", 32'h1, {31'h0, pdm_output_enable});
        foreach (ad[i]) if (i < 7 && i != 2) wr(ad[i], 8'h00);
        settle(2);
        chk("prog_counter_enable", 32'h0, {31'h0, prog_counter_enable});
        chk("p3_oe", 32'h0, {28'h0, p3_oe});
    endtask
    task automatic t_port1();
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'hff);
        settle(4);
        rd(8'h80, 8'hff);
        @(posedge ref_clk);
        d1_en <= 8'hff;
        d1_v <= 8'h3c;
        settle(4);
        rd(8'h80, 8'h3c);
        wr(8'h8c, 8'h0f);
        rd(8'h80, 8'h0c);
        chk("p1_analog_en", 32'hf0, {24'h0, p1_analog_en});
        @(posedge ref_clk);
        d1_en <= 8'h00;
        wr(8'h84, 8'hff);
        wr(8'h80, 8'ha5);
        settle(1);
        chk("p1_out", 32'ha5, {24'h0, p1_out});
        rd(8'h80, 8'ha5);
        wr(8'h84, 8'h00);
    endtask
    task automatic t_port2();
        wr(8'h9c, 8'h90);
        @(posedge ref_clk);
        buzzer_in <= 1'b1;
        settle(3);
        chk("p2_oe_fn", 32'h84, {24'h0, p2_oe & 8'h84});
        chk("p2_out_fn", 32'h80, {24'h0, p2_out & 8'h84});
        @(posedge ref_clk);
        buzzer_in <= 1'b0;
        pdm_in <= 1'b1;
        settle(3);
        chk("p2_out_fn", 32'h04, {24'h0, p2_out & 8'h84});
        wr(8'h9c, 8'h00);
        settle(2);
        chk("p2_oe_fn", 32'h0, {24'h0, p2_oe & 8'h84});
        wr(8'h94, 8'h18);
        wr(8'h90, 8'h08);
        settle(2);
        chk("p2_oe_od", 32'h10, {24'h0, p2_oe & 8'h18});
        chk("p2_out_od", 32'h00, {24'h0, p2_out & 8'h18});
        wr(8'hdc, 8'h00);
        settle(2);
        chk("p2_oe_pp", 32'h18, {24'h0, p2_oe & 8'h18});
        chk("p2_out_pp", 32'h08, {24'h0, p2_out & 8'h18});
        wr(8'h94, 8'h00);
        settle(2);
        chk("p2_oe", 32'h0, {24'h0, p2_oe});
    endtask
    task automatic t_irq();
        logic [7:0] s [4];
        logic [1:0] m;
        @(posedge ref_clk);
        d2_en <= 8'h03;
        d2_v <= 8'h00;
        d3_en <= 4'h3;
        d3_v <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr(8'h9c, {4'h0, m, m});
            wr(8'hac, {4'h0, m, m});
            settle(6);
            s = ev_cnt;
            @(posedge ref_clk);
            d2_v <= 8'h03;
            d3_v <= 4'h3;
            settle(8);
            for (int j = 0; j < 4; j++) chk("rise_events", {31'h0, m != 2'b00}, {24'h0, ev_cnt[j] - s[j]});
            s = ev_cnt;
            @(posedge ref_clk);
            d2_v <= 8'h00;
            d3_v <= 4'h0;
            settle(8);
            for (int j = 0; j < 4; j++) chk("fall_events", {31'h0, m != 2'b01}, {24'h0, ev_cnt[j] - s[j]});
        end
        wr(8'h98, 8'hff);
        wr(8'ha8, 8'h0f);
        rd(8'h90, 8'hfc);
        rd(8'ha0, 8'h0c);
    endtask
    initial begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, buzzer_in, pdm_in} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {d1_en, d1_v, d2_en, d2_v, d3_en, d3_v} = 40'h0;
        ev_cnt = '{default: 8'h00};
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_port1();
        t_port2();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
